//--- bcr_pkg.sv
/*
  package for the regulator configuration register bank: offsets, fields, reset values, codes.
  assumes a byte-wide register access port driven by the serial interface front end.
*/
`default_nettype none
package bcr_pkg;
  // register addresses in the 9-bit mapped space
  localparam logic [8:0] BCR_OFS_PAGE = 9'h080;
  localparam logic [8:0] BCR_OFS_ILIM = 9'h0d0;
  localparam logic [8:0] BCR_OFS_CONF1 = 9'h0d1;
  localparam logic [8:0] BCR_OFS_CONF2 = 9'h0d2;
  localparam logic [8:0] BCR_OFS_AUTO = 9'h0d4;
  localparam logic [8:0] BCR_OFS_BASE = 9'h0d5;
  // field positions
  localparam int BCR_PAGE_REVERT_BIT = 7;
  localparam int BCR_PAGE_WMODE_BIT = 6;
  localparam int BCR_ALARM_BIT = 4;
  localparam int BCR_SHED_BIT = 3;
  // writable masks, reserved bits zero
  localparam logic [7:0] BCR_MASK_PAGE = 8'hc7;
  localparam logic [7:0] BCR_MASK_ILIM = 8'h1f;
  localparam logic [7:0] BCR_MASK_CONF1 = 8'hff;
  localparam logic [7:0] BCR_MASK_CONF2 = 8'h0f;
  localparam logic [7:0] BCR_MASK_VOLT = 8'h7f;
  // reset values
  localparam logic [7:0] BCR_RST_PAGE = 8'h00;
  localparam logic [7:0] BCR_RST_ILIM = 8'h00;
  localparam logic [7:0] BCR_RST_CONF1 = 8'h00;
  localparam logic [7:0] BCR_RST_CONF2 = 8'h03;
  localparam logic [7:0] BCR_RST_VOLT = 8'h00;
  // physical scales
  localparam int BCR_ILIM_BASE_MA = 1600;
  localparam int BCR_ILIM_STEP_MA = 200;
  localparam int BCR_ALARM_SMALL_MA = 300;
  localparam int BCR_ALARM_LARGE_MA = 600;
  localparam int BCR_VOLT_BASE_MV = 300;
  localparam int BCR_VOLT_STEP_MV = 10;
  // page-select and ramp codes
  localparam logic [2:0] BCR_PAGE_ZERO = 3'h0;
  localparam logic [2:0] BCR_RAMP_NONE = 3'h7;
  // operating mode field
  typedef enum logic [1:0] {
    BCR_MODE_REG = 2'b00,
    BCR_MODE_LP = 2'b01,
    BCR_MODE_NORM = 2'b10,
    BCR_MODE_AUTO = 2'b11
  } bcr_mode_type;
endpackage : bcr_pkg
`default_nettype wire

//--- bcr_page_map.sv
/*
  page mapper: turns page select plus 8-bit access address into a 9-bit register address.
  assumes the caller says whether the access comes over the two-wire or four-wire link.
*/
`timescale 1ns/10ps
`default_nettype none
module bcr_page_map (
  // access request
  input wire logic [2:0] page_sel,
  input wire logic [7:0] addr,
  input wire logic is_spi,
  // mapped result
  output logic [8:0] reg_addr,
  output logic valid
);
  import bcr_pkg::*;
  // two-wire: 8-bit addresses span a 256 register page; bit 1 picks the upper bank
  // two-wire mapping
  wire logic [8:0] i2c_addr = page_sel[1] ? {1'b1, 1'b0, addr[6:0]} : {1'b0, addr};
  // two-wire upper bank only holds 0x100..0x17f
  wire logic i2c_ok = ~page_sel[2] & (~page_sel[1] | ~addr[7]);
  // four-wire: 7-bit addresses, 128 register pages
  // four-wire mapping
  wire logic [8:0] spi_addr = {page_sel[1:0], addr[6:0]};
  // codes above 010 are test pages; treated as unmapped
  wire logic spi_ok = (page_sel <= 3'h2);
  assign reg_addr = is_spi ? spi_addr : i2c_addr;
  assign valid = is_spi ? spi_ok : i2c_ok;
endmodule : bcr_page_map
`default_nettype wire

//--- bcr_regs.sv
/*
  configuration register bank for a multi-phase step-down regulator: page control,
  current limit, ramps, mode, phases, automatic threshold and voltage port base.
  assumes a serial front end giving one-cycle read and write strobes, an end-of-access
  pulse, and the voltage-set low-power bits from the voltage registers outside.
*/
`timescale 1ns/10ps
`default_nettype none
// What this block does
// - revert clears page after access ends
// - bit 6 picks page or repeated write
// - write mode ignored on four-wire link
// - two-wire page map 00x and 01x
// - four-wire page map 000 001 010
// - current limit 1600 mA plus 200 steps
// - alarm offset 300 or 600 mA
// - power-down slew code, 111 reserved
// - start-up slew, 111 means no ramp
// - mode field selects regulator mode
// - shedding only in normal mode
// - phase count select, 1xx dual eight
// - auto threshold 0.30 V 10 mV steps
// - voltage port base same encoding
// - set top bit picks low power
module bcr_regs #(
  parameter int ADDR_W = 8
) (
  // clock and reset
  input wire logic CLK,
  input wire logic RST,
  // register access from the serial front end
  input wire logic ACC_SPI,
  input wire logic [7:0] ACC_ADDR,
  input wire logic ACC_WR,
  input wire logic ACC_RD,
  input wire logic [7:0] ACC_WDATA,
  input wire logic ACC_DONE,
  output logic [7:0] ACC_RDATA,
  output logic ACC_HIT,
  // page state to the front end
  output logic [2:0] PAGE_SELECT,
  output logic REPEATED_WRITE,
  // voltage-set, auto threshold and dual-device inputs
  input wire logic SET_B_ACTIVE,
  input wire logic SET_A_LOW_POWER_SELECT,
  input wire logic SET_B_LOW_POWER_SELECT,
  input wire logic AUTO_ABOVE_THRESHOLD,
  input wire logic DUAL_DEVICE,
  // regulator controls
  output logic [3:0] PHASE_CURRENT_LIMIT,
  output logic ALARM_OFFSET_SELECT,
  output logic [12:0] CURRENT_LIMIT_MA,
  output logic [12:0] ALARM_LEVEL_MA,
  output logic [2:0] SHUTDOWN_SLEW,
  output logic SHUTDOWN_SLEW_VALID,
  output logic [2:0] STARTUP_SLEW,
  output logic STARTUP_IMMEDIATE,
  output logic LOW_POWER_MODE,
  output logic [3:0] ACTIVE_PHASES,
  output logic UNEVEN_SHIFT,
  output logic PHASE_SHEDDING_ENABLE,
  output logic SHEDDING_ACTIVE,
  output logic [6:0] AUTO_MODE_THRESHOLD,
  output logic [10:0] AUTO_THRESHOLD_MV,
  output logic [6:0] VOLTAGE_PORT_BASE,
  output logic [10:0] VOLTAGE_PORT_BASE_MV
);
  import bcr_pkg::*;

  // the address decoder below only serves byte-wide access addresses;
  // a wider address would need a different page split in the mapper
  if (ADDR_W != 8) begin : g_addr_w_check
    $error("bcr_regs serves only 8-bit access addresses");
  end

  // register state
  logic [7:0] page_q, page_d; // page control
  logic [7:0] ilim_q; // current limit and alarm
  logic [7:0] conf1_q; // ramps and mode
  logic [7:0] conf2_q; // phases and shedding
  logic [7:0] auto_q; // automatic threshold
  logic [7:0] base_q; // voltage port base
  logic pend_revert_q; // an access has touched the bank since done
  // page_d and pend_d are the next-value signals; the others load straight from the bus

  // mapped address from the page mapper
  logic [8:0] map_addr;
  logic map_ok;

  // the mapper is pure logic, kept apart so the link front end can share it
  bcr_page_map u_map (
    .page_sel(page_q[2:0]),
    .addr(ACC_ADDR),
    .is_spi(ACC_SPI),
    .reg_addr(map_addr),
    .valid(map_ok)
  );

  // address decode
  // the full 9-bit mapped address is compared, so no page aliases a register
  wire logic sel_page = map_ok && (map_addr == BCR_OFS_PAGE);
  wire logic sel_ilim = map_ok && (map_addr == BCR_OFS_ILIM);
  wire logic sel_conf1 = map_ok && (map_addr == BCR_OFS_CONF1);
  wire logic sel_conf2 = map_ok && (map_addr == BCR_OFS_CONF2);
  wire logic sel_auto = map_ok && (map_addr == BCR_OFS_AUTO);
  wire logic sel_base = map_ok && (map_addr == BCR_OFS_BASE);
  wire logic any_sel = sel_page | sel_ilim | sel_conf1 | sel_conf2 | sel_auto | sel_base;

  // write enables, one per register; a strobe to an unmapped address lands nowhere
  wire logic wr_page = ACC_WR && sel_page;
  wire logic wr_ilim = ACC_WR && sel_ilim;
  wire logic wr_conf1 = ACC_WR && sel_conf1;
  wire logic wr_conf2 = ACC_WR && sel_conf2;
  wire logic wr_auto = ACC_WR && sel_auto;
  wire logic wr_base = ACC_WR && sel_base;

  // read mux; unmapped reads return zero
  // a priority chain is safe here: the selects are one-hot by construction
  wire logic [7:0] rd_mux =
    sel_page ? page_q :
    sel_ilim ? ilim_q :
    sel_conf1 ? conf1_q :
    sel_conf2 ? conf2_q :
    sel_auto ? auto_q :
    sel_base ? base_q : 8'h00;

  // revert waits for a finished access
  // a bare end of transfer with no register access leaves the page alone,
  // so a host that only probes the device address keeps its page
  wire logic access_seen = pend_revert_q | ACC_RD | ACC_WR;
  wire logic revert_now = ACC_DONE & access_seen;
  // an end clears the flag even when a strobe shares its cycle
  wire logic pend_d = ~ACC_DONE & access_seen;

  // page register next value: write first, then the revert on access end
  // revert acts on the value just written, so one transfer can set it and fall back
  always_comb begin
    page_d = page_q;
    if (wr_page) begin
      page_d = ACC_WDATA & BCR_MASK_PAGE;
    end
    if (revert_now && page_d[BCR_PAGE_REVERT_BIT]) begin
      page_d[2:0] = BCR_PAGE_ZERO;
    end
  end

  // page register and revert tracking
  always_ff @(posedge CLK) begin
    if (RST) begin
      page_q <= BCR_RST_PAGE;
      pend_revert_q <= 1'b0;
    end else begin
      page_q <= page_d;
      pend_revert_q <= pend_d;
    end
  end

  // regulator setting registers; write data masked so reserved bits stay zero
  // storing only writable bits means reads need no separate mask, and a
  // reserved bit can never leak into a decoded control
  always_ff @(posedge CLK) begin
    if (RST) begin
      ilim_q <= BCR_RST_ILIM;
      conf1_q <= BCR_RST_CONF1;
      conf2_q <= BCR_RST_CONF2;
      auto_q <= BCR_RST_VOLT;
      base_q <= BCR_RST_VOLT;
    end else begin
      if (wr_ilim) begin
        ilim_q <= ACC_WDATA & BCR_MASK_ILIM;
      end
      if (wr_conf1) begin
        conf1_q <= ACC_WDATA & BCR_MASK_CONF1;
      end
      if (wr_conf2) begin
        conf2_q <= ACC_WDATA & BCR_MASK_CONF2;
      end
      if (wr_auto) begin
        auto_q <= ACC_WDATA & BCR_MASK_VOLT;
      end
      if (wr_base) begin
        base_q <= ACC_WDATA & BCR_MASK_VOLT;
      end
    end
  end

  // read data is registered on the read strobe
  // holding it between reads lets a slow front end shift it out at leisure
  always_ff @(posedge CLK) begin
    if (RST) begin
      ACC_RDATA <= 8'h00;
    end else if (ACC_RD) begin
      ACC_RDATA <= rd_mux;
    end
  end

  // hit flag is combinational handshake
  // the front end uses it to decide whether to answer the transfer at all
  assign ACC_HIT = any_sel;

  // page state to front end
  assign PAGE_SELECT = page_q[2:0];
  // combinational, so it follows the link of the transfer in flight
  // multiple write mode
  assign REPEATED_WRITE = page_q[BCR_PAGE_WMODE_BIT] & ~ACC_SPI;

  // current limit decode; wide enough for 4600 mA
  // the smallest alarm level is 1000 mA, so the subtraction never wraps
  localparam logic [12:0] ILIM_BASE = 13'(BCR_ILIM_BASE_MA);
  localparam logic [12:0] ILIM_STEP = 13'(BCR_ILIM_STEP_MA);
  localparam logic [12:0] ALARM_SMALL = 13'(BCR_ALARM_SMALL_MA);
  localparam logic [12:0] ALARM_LARGE = 13'(BCR_ALARM_LARGE_MA);
  wire logic [12:0] ilim_ma = 13'(ILIM_BASE + ILIM_STEP * {9'h000, ilim_q[3:0]});
  wire logic [12:0] alarm_ma = 13'(ilim_ma - (ilim_q[BCR_ALARM_BIT] ? ALARM_LARGE : ALARM_SMALL));

  // ramp decode
  // the reserved shutdown code is only flagged; the analogue side picks a fallback
  // shutdown slew, 111 reserved
  wire logic sd_valid = (conf1_q[7:5] != BCR_RAMP_NONE);
  wire logic su_now = (conf1_q[4:2] == BCR_RAMP_NONE);

  // mode decode
  // auto mode trusts the comparator outside; this bank measures nothing
  // the voltage-set bit is taken live, so a set switch changes the mode at once
  bcr_mode_type mode;
  assign mode = bcr_mode_type'(conf1_q[1:0]);
  wire logic set_lp = SET_B_ACTIVE ? SET_B_LOW_POWER_SELECT : SET_A_LOW_POWER_SELECT;
  logic lp_mode;
  always_comb begin
    case (mode)
      BCR_MODE_REG: lp_mode = set_lp;
      BCR_MODE_LP: lp_mode = 1'b1;
      BCR_MODE_NORM: lp_mode = 1'b0;
      BCR_MODE_AUTO: lp_mode = ~AUTO_ABOVE_THRESHOLD;
      default: lp_mode = 1'b0;
    endcase
  end

  // phase count decode
  // without a partner device a 1xx code runs the four local phases, so a
  // lone device never reports phases it cannot switch
  logic [3:0] phases;
  always_comb begin
    if (conf2_q[2]) begin
      // eight phases only make sense with a partner device
      phases = DUAL_DEVICE ? 4'h8 : 4'h4;
    end else begin
      phases = 4'({2'b00, conf2_q[1:0]} + 4'h1);
    end
  end

  wire logic uneven = (conf2_q[2:0] == 3'h2);

  // voltage decodes in millivolts
  // 11 bits reach 1570 mV, the top code
  localparam logic [10:0] VOLT_BASE = 11'(BCR_VOLT_BASE_MV);
  localparam logic [10:0] VOLT_STEP = 11'(BCR_VOLT_STEP_MV);
  wire logic [10:0] auto_mv = 11'(VOLT_BASE + VOLT_STEP * {4'h0, auto_q[6:0]});
  wire logic [10:0] base_mv = 11'(VOLT_BASE + VOLT_STEP * {4'h0, base_q[6:0]});

  // control outputs straight from register state, except low power, shedding and phase count, which also use the set, threshold and dual-device inputs
  // current limit field
  assign PHASE_CURRENT_LIMIT = ilim_q[3:0];
  assign ALARM_OFFSET_SELECT = ilim_q[BCR_ALARM_BIT];
  assign CURRENT_LIMIT_MA = ilim_ma;
  assign ALARM_LEVEL_MA = alarm_ma;
  assign SHUTDOWN_SLEW = conf1_q[7:5];
  assign SHUTDOWN_SLEW_VALID = sd_valid;
  assign STARTUP_SLEW = conf1_q[4:2];
  assign STARTUP_IMMEDIATE = su_now;
  assign LOW_POWER_MODE = lp_mode;
  assign ACTIVE_PHASES = phases;
  assign UNEVEN_SHIFT = uneven;
  assign PHASE_SHEDDING_ENABLE = conf2_q[BCR_SHED_BIT];
  assign SHEDDING_ACTIVE = conf2_q[BCR_SHED_BIT] & ~lp_mode;
  assign AUTO_MODE_THRESHOLD = auto_q[6:0];
  assign AUTO_THRESHOLD_MV = auto_mv;
  assign VOLTAGE_PORT_BASE = base_q[6:0];
  assign VOLTAGE_PORT_BASE_MV = base_mv;
endmodule : bcr_regs
`default_nettype wire

//--- bcr_regs_assertions.sv
/*
  checker for the regulator configuration bank: decoded outputs and access behaviour.
  assumes it is bound into bcr_regs and sees only that module's ports.
*/
`timescale 1ns/10ps
`default_nettype none
module bcr_regs_chk (
  // clock, reset and access
  input wire logic CLK, RST, ACC_SPI, ACC_WR, ACC_RD, ACC_DONE, ACC_HIT,
  input wire logic [7:0] ACC_RDATA,
  // page state, slews, alarm select, mode and shedding flags
  input wire logic [2:0] PAGE_SELECT, SHUTDOWN_SLEW, STARTUP_SLEW,
  input wire logic REPEATED_WRITE, ALARM_OFFSET_SELECT, SHUTDOWN_SLEW_VALID,
  input wire logic STARTUP_IMMEDIATE, LOW_POWER_MODE, PHASE_SHEDDING_ENABLE, SHEDDING_ACTIVE,
  // scaled values
  input wire logic [3:0] PHASE_CURRENT_LIMIT,
  input wire logic [12:0] CURRENT_LIMIT_MA, ALARM_LEVEL_MA,
  input wire logic [6:0] AUTO_MODE_THRESHOLD, VOLTAGE_PORT_BASE,
  input wire logic [10:0] AUTO_THRESHOLD_MV, VOLTAGE_PORT_BASE_MV
);
  // one clock domain, checks quiet while reset is high
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);
  ilim_scale_a: assert property (CURRENT_LIMIT_MA == 1600 + 200 * PHASE_CURRENT_LIMIT)
    else $error("current limit scale wrong");
  alarm_level_a: assert property (ALARM_LEVEL_MA ==
    CURRENT_LIMIT_MA - (ALARM_OFFSET_SELECT ? 600 : 300)) else $error("alarm level wrong");
  // page may only move on a write or an access end; a past reset also clears it
  page_change_cause_a: assert property (PAGE_SELECT != $past(PAGE_SELECT) |->
    $past(ACC_WR || ACC_DONE || RST)) else $error("page moved without cause");
  unmapped_read_zero_a: assert property (ACC_RD && !ACC_HIT |=> ACC_RDATA == 8'h00)
    else $error("unmapped read not zero");
  spi_no_repeat_a: assert property (ACC_SPI |-> !REPEATED_WRITE)
    else $error("repeated write on four-wire link");
  startup_now_a: assert property (STARTUP_IMMEDIATE == (STARTUP_SLEW == 3'h7))
    else $error("start-up immediate flag wrong");
  shutdown_valid_a: assert property (SHUTDOWN_SLEW_VALID == (SHUTDOWN_SLEW != 3'h7))
    else $error("shutdown slew valid flag wrong");
  shed_normal_a: assert property (SHEDDING_ACTIVE ==
    (PHASE_SHEDDING_ENABLE && !LOW_POWER_MODE)) else $error("shedding outside normal mode");
  auto_volt_a: assert property (AUTO_THRESHOLD_MV == 300 + 10 * AUTO_MODE_THRESHOLD)
    else $error("auto threshold scale wrong");
  base_volt_a: assert property (VOLTAGE_PORT_BASE_MV == 300 + 10 * VOLTAGE_PORT_BASE)
    else $error("voltage port base scale wrong");
  // main scenarios
  write_seen_c: cover property (ACC_WR && ACC_HIT);
  read_seen_c: cover property (ACC_RD && !ACC_HIT);
  revert_seen_c: cover property (ACC_DONE && PAGE_SELECT != 3'h0 ##1 PAGE_SELECT == 3'h0);
endmodule : bcr_regs_chk
bind bcr_regs bcr_regs_chk chk_u (.*);
`default_nettype wire

//--- bcr_host.sv
/*
  host model: issues single byte accesses to the bank over either link.
  assumes the bench calls acc between clock edges, never twice in one time step.
*/
`timescale 1ns/10ps
`default_nettype none
module bcr_host (
  // clock
  input wire logic CLK,
  // access toward the bank
  output logic ACC_SPI, ACC_WR, ACC_RD, ACC_DONE,
  output logic [7:0] ACC_ADDR, ACC_WDATA
);
  // idle link at time zero
  initial begin
    ACC_SPI = 1'b0;
    ACC_WR = 1'b0;
    ACC_RD = 1'b0;
    ACC_DONE = 1'b0;
    ACC_ADDR = 8'h00;
    ACC_WDATA = 8'h00;
  end
  // bench never asks four-wire pages above 010
  // raise at an edge, taken at the next, then release with inverted lines
  task automatic acc(input logic spi, wr, done, input logic [7:0] a, d);
    @(posedge CLK);
    ACC_SPI <= spi;
    ACC_WR <= wr;
    ACC_RD <= !wr;
    ACC_DONE <= done;
    ACC_ADDR <= a;
    ACC_WDATA <= d;
    @(posedge CLK);
    ACC_WR <= 1'b0;
    ACC_RD <= 1'b0;
    ACC_DONE <= 1'b0;
    ACC_ADDR <= ~a;
    ACC_WDATA <= ~d;
  endtask : acc
endmodule : bcr_host
`default_nettype wire

//--- bcr_regs_tb.sv
/*
  bench for the configuration bank: register access, decoding and page handling.
  assumes bcr_host as the access driver and the checker bound by its own file.
*/
`timescale 1ns/10ps
`default_nettype none
module bcr_regs_tb;
  import bcr_pkg::*;
  logic clk, rst, sbact, sla, slb, above, dual, spi, wr_s, rd_s, done, rep, lpm, uneven, shed, lp;
  logic [7:0] addr, wdata, rdata, v;
  logic [2:0] page;
  logic [3:0] act;
  logic [12:0] cur_ma, alarm_ma;
  logic [3:0] plim;
  logic asel, sdv, sui, pshed;
  logic [2:0] sd, su;
  logic [6:0] acode, bcode, bv;
  logic [10:0] amv, bmv;
  int lim;
  logic [7:0] q[$];
  logic rd_d = 1'b0;
  logic [7:0] offs [5] = '{8'hd0, 8'hd1, 8'hd2, 8'hd4, 8'hd5};
  logic [7:0] msk [5] = '{BCR_MASK_ILIM, BCR_MASK_CONF1, BCR_MASK_CONF2, BCR_MASK_VOLT, BCR_MASK_VOLT};
  integer seed = 32'hba78b69c;
  int err_total = 0;
  int cmp_count = 0;
  int cyc = 0;
  bcr_host host_u (.CLK(clk), .ACC_SPI(spi), .ACC_WR(wr_s), .ACC_RD(rd_s), .ACC_DONE(done),
    .ACC_ADDR(addr), .ACC_WDATA(wdata));
  bcr_regs dut_u (.CLK(clk), .RST(rst), .ACC_SPI(spi), .ACC_ADDR(addr), .ACC_WR(wr_s),
    .ACC_RD(rd_s), .ACC_WDATA(wdata), .ACC_DONE(done), .ACC_RDATA(rdata), .ACC_HIT(),
    .PAGE_SELECT(page), .REPEATED_WRITE(rep), .SET_B_ACTIVE(sbact),
    .SET_A_LOW_POWER_SELECT(sla), .SET_B_LOW_POWER_SELECT(slb), .AUTO_ABOVE_THRESHOLD(above),
    .DUAL_DEVICE(dual), .PHASE_CURRENT_LIMIT(plim), .ALARM_OFFSET_SELECT(asel),
    .CURRENT_LIMIT_MA(cur_ma), .ALARM_LEVEL_MA(alarm_ma), .SHUTDOWN_SLEW(sd),
    .SHUTDOWN_SLEW_VALID(sdv), .STARTUP_SLEW(su), .STARTUP_IMMEDIATE(sui),
    .LOW_POWER_MODE(lpm), .ACTIVE_PHASES(act), .UNEVEN_SHIFT(uneven),
    .PHASE_SHEDDING_ENABLE(pshed), .SHEDDING_ACTIVE(shed), .AUTO_MODE_THRESHOLD(acode),
    .AUTO_THRESHOLD_MV(amv), .VOLTAGE_PORT_BASE(bcode), .VOLTAGE_PORT_BASE_MV(bmv));
  // 100 ns clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task automatic check(input string n, input logic [12:0] seen, exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", n, exp, seen);
    end
  endtask : check
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : end_of_test
  // a write shows in the decoded outputs one cycle later
  task automatic wr(input logic s, dn, input logic [7:0] a, d);
    host_u.acc(s, 1'b1, dn, a, d);
    @(negedge clk);
  endtask : wr
  // expected read data goes in the queue before the access starts
  task automatic rd(input logic s, input logic [7:0] a, exp);
    q.push_back(exp);
    host_u.acc(s, 1'b0, 1'b0, a, 8'h00);
    @(negedge clk);
  endtask : rd
  // read data lands on the edge that takes the strobe
  always @(posedge clk) rd_d <= rd_s;
  always @(negedge clk) if (rd_d) check("read data", rdata, q.pop_front());
  // hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      err_total++;
      end_of_test();
    end
  end
  initial begin
    {rst, sbact, sla, slb, above, dual} = 6'h20;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    rd(0, 8'hd2, BCR_RST_CONF2);
    rd(0, 8'h80, BCR_RST_PAGE);
    rd(0, 8'hd3, 8'h00);
    // each of the five setting registers keeps its writable bits only
    for (int i = 0; i < 5; i++) begin
      v = $random(seed);
      // start-up codes 101 and 110 kept out
      if (i == 1 && v[4] && (v[3] != v[2])) v[3:2] = 2'b00;
      wr(0, 0, offs[i], v);
      rd(0, offs[i], v & msk[i]);
    end
    for (int c = 0; c < 32; c++) begin
      wr(0, 0, 8'hd0, c[7:0]);
      lim = BCR_ILIM_BASE_MA + BCR_ILIM_STEP_MA * (c % 16);
      check("limit", cur_ma, 13'(lim));
      check("limit code", plim, c[3:0]);
      check("alarm", alarm_ma, 13'(lim - (c[4] ? BCR_ALARM_LARGE_MA : BCR_ALARM_SMALL_MA)));
      check("alarm select", asel, c[4]);
    end
    // all phase codes with and without the dual device, shedding on odd codes
    for (int c = 0; c < 16; c++) begin
      @(posedge clk) dual <= c[3];
      wr(0, 0, 8'hd2, {4'h0, c[0], c[2:0]});
      check("phases", act, c[2] ? (c[3] ? 4'h8 : 4'h4) : 4'(c[2:0] + 1));
      check("uneven", uneven, c[2:0] == 3'h2);
      check("shed enable", pshed, c[0]);
    end
    // every shutdown code; start-up codes 000 to 100 and 111 only
    for (int c = 0; c < 8; c++) begin
      v = {c[2:0], (c > 4) ? 3'h7 : c[2:0], 2'b10};
      wr(0, 0, 8'hd1, v);
      check("shutdown slew", sd, c[2:0]);
      check("shutdown valid", sdv, c != 7);
      check("startup slew", su, v[4:2]);
      check("startup immediate", sui, c > 4);
    end
    // end codes first, then random codes, reserved bit set on the base write
    for (int c = 0; c < 4; c++) begin
      v = (c == 0) ? 8'h00 : ((c == 1) ? 8'hff : 8'($random(seed)));
      bv = ~v[6:0];
      wr(0, 0, 8'hd4, v);
      wr(0, 0, 8'hd5, {1'b1, bv});
      check("auto code", acode, v[6:0]);
      check("auto mv", amv, 13'(BCR_VOLT_BASE_MV + BCR_VOLT_STEP_MV * v[6:0]));
      check("base code", bcode, bv);
      check("base mv", bmv, 13'(BCR_VOLT_BASE_MV + BCR_VOLT_STEP_MV * bv));
    end
    // every mode against random voltage-set levels
    for (int c = 0; c < 16; c++) begin
      v = $random(seed);
      @(posedge clk) {sbact, sla, slb, above} <= v[3:0];
      wr(0, 0, 8'hd1, {6'h00, c[1:0]});
      lp = c[1] ? (c[0] ? !v[0] : 1'b0) : (c[0] ? 1'b1 : (v[3] ? v[1] : v[2]));
      check("low power", lpm, lp);
      check("shed", shed, !lp);
    end
    // two-wire page 0 reaches page_control; reserved bits dropped
    wr(0, 0, 8'h80, 8'h79);
    check("page", page, 3'h1);
    check("repeat", rep, 1'b1);
    rd(1, 8'h50, 8'h1f);
    check("repeat four-wire", rep, 1'b0);
    // revert with the end of the access in the write cycle
    wr(1, 1, 8'h00, 8'hb9);
    @(negedge clk);
    check("revert", page, 3'h0);
    rd(0, 8'h80, 8'h80);
    check("page write", rep, 1'b0);
    // no revert bit, so an access end keeps the page
    wr(0, 1, 8'h80, 8'h01);
    @(negedge clk);
    check("kept", page, 3'h1);
    end_of_test();
  end
endmodule : bcr_regs_tb
`default_nettype wire
